// File: pbrbs_params.svh
// Constants of the power button, reset pin and boot sampler block
// Contract
// - In OFF, a brief power button press moves the power state to ON.
// - In ON, a brief press raises an interrupt pulse and leaves the state alone.
// - Holding the button about five seconds or more forces the state to OFF.
// - Real-time reset pin is driven low, open-drain, while the real-time core is reset.
// - Real-time reset pin is an input with pull-up while the core runs.
// - An external low on the real-time reset pin gives a full power-on reset.
// - Application reset pin is driven low, open-drain, while the application core is reset.
// - Application reset pin is an input with pull-up while that core runs.
// - The block exposes no readable power button level; use a separate input.
// - Both boot select inputs carry pull-downs, so open inputs read zero.
// - Boot select inputs are sampled at reset release into the boot mode register.
// - With fuse boot configuration enabled the boot select inputs are ignored.
`ifndef PBRBS_PARAMS_SVH
`define PBRBS_PARAMS_SVH

`define PBRBS_CLK_HZ        125000000
`define PBRBS_FORCE_OFF_S   5
`define PBRBS_DEBOUNCE_US   10000
`define PBRBS_HOLD_W        30
`define PBRBS_DB_W          21
`define PBRBS_RST_STRETCH   8'h10
`define PBRBS_APP_DELAY     8'h20
`define PBRBS_BLANK         4'h4
`define PBRBS_BOOT_INIT     2'h0
`define PBRBS_PD_ON         2'h3
`define PBRBS_SYNC_INIT     4'h8
`define PBRBS_SYNC_BTN      3
`define PBRBS_SYNC_RT       2
`define PBRBS_SYNC_BOOT1    1
`define PBRBS_SYNC_BOOT0    0

`endif

// File: pbrbs_pkg.sv
// Types shared by the power button, reset pin and boot sampler block
`include "pbrbs_params.svh"
package pbrbs_pkg;

    typedef enum logic {
        PWR_OFF,
        PWR_ON
    } pbrbs_pwr_t;

    // Open-drain pin with pull-up control
    typedef struct packed {
        logic out;
        logic oe;
        logic pu_en;
    } pbrbs_od_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
    } pbrbs_sync_t;

    typedef struct packed {
        logic [`PBRBS_DB_W-1:0] cnt;
        logic                   level_n;
    } pbrbs_db_t;

    typedef struct packed {
        pbrbs_pwr_t               pwr;
        logic                     pwr_on;
        logic                     irq;
        logic                     rt_rst;
        logic [7:0]               rst_cnt;
        logic [3:0]               blank_cnt;
        logic                     app_rst;
        logic [7:0]               app_cnt;
        logic [`PBRBS_HOLD_W-1:0] hold_cnt;
        logic                     btn_prev_n;
        logic [1:0]               boot_mode;
        logic [1:0]               boot_pd_en;
        pbrbs_od_t                rt_pin;
        pbrbs_od_t                app_pin;
    } pbrbs_state_t;

endpackage : pbrbs_pkg

// File: pbrbs_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`include "pbrbs_params.svh"
module pbrbs_sync
    import pbrbs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] d,
    output logic      [3:0] q
);
    pbrbs_sync_t s_ff;
    pbrbs_sync_t nxt_s;

    always_comb begin
        nxt_s    = s_ff;
        nxt_s.s1 = d;
        nxt_s.s2 = s_ff.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= '{s1: `PBRBS_SYNC_INIT, s2: `PBRBS_SYNC_INIT};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.s2;
endmodule : pbrbs_sync

// File: pbrbs_debounce.sv
// Debouncer for the synchronised power button level
`timescale 1ns/1ps
`include "pbrbs_params.svh"
module pbrbs_debounce
    import pbrbs_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = `PBRBS_DEBOUNCE_US * (`PBRBS_CLK_HZ / 1000000)
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic raw_n,
    output logic      level_n
);
    localparam logic [`PBRBS_DB_W-1:0] DB_LAST = `PBRBS_DB_W'(DEBOUNCE_CYC - 1);

    pbrbs_db_t s_ff;
    pbrbs_db_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (raw_n == s_ff.level_n) begin
            nxt_s.cnt = '0;
        end else if (s_ff.cnt == DB_LAST) begin
            nxt_s.cnt     = '0;
            nxt_s.level_n = raw_n;
        end else begin
            nxt_s.cnt = s_ff.cnt + `PBRBS_DB_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= '{cnt: '0, level_n: 1'b1};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign level_n = s_ff.level_n;

    chk_debounce_hold: assert property (@(posedge clk) disable iff (rst)
        (s_ff.level_n != $past(s_ff.level_n)) |-> ($past(s_ff.cnt) == DB_LAST))
        else $error("debounced level changed before the interval ran out");
endmodule : pbrbs_debounce

// File: pbrbs_sequencer.sv
// Power button state machine, reset pin handling and boot mode sampling
`timescale 1ns/1ps
`include "pbrbs_params.svh"
module pbrbs_sequencer
    import pbrbs_pkg::*;
#(
    parameter int unsigned FORCE_OFF_CYC = `PBRBS_FORCE_OFF_S * `PBRBS_CLK_HZ,
    parameter int unsigned DEBOUNCE_CYC  = `PBRBS_DEBOUNCE_US * (`PBRBS_CLK_HZ / 1000000)
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       power_button_n,
    input  wire logic       rt_domain_reset_n_sense,
    input  wire logic       boot_sel_bit0,
    input  wire logic       boot_sel_bit1,
    input  wire logic       fuse_boot_en,
    input  wire logic [1:0] fuse_boot_mode,
    output pbrbs_od_t       rt_domain_reset_n_pin,
    output pbrbs_od_t       app_core_reset_ind_n_pin,
    output logic            rt_core_rst,
    output logic            app_core_rst,
    output logic            pwr_on,
    output logic            pwr_irq,
    output logic [1:0]      boot_mode,
    output logic [1:0]      boot_sel_pd_en
);
    localparam logic [`PBRBS_HOLD_W-1:0] HOLD_LAST  = `PBRBS_HOLD_W'(FORCE_OFF_CYC - 1);
    localparam logic [7:0]               RST_LAST   = `PBRBS_RST_STRETCH - 8'h01;
    localparam logic [7:0]               APP_LAST   = `PBRBS_APP_DELAY - 8'h01;

    localparam pbrbs_od_t OD_DRIVE = '{out: 1'b0, oe: 1'b1, pu_en: 1'b0};
    localparam pbrbs_od_t OD_INPUT = '{out: 1'b0, oe: 1'b0, pu_en: 1'b1};

    // Power-up values; an external reset on the pin restores them too
    localparam pbrbs_state_t ST_INIT = '{
        pwr:        PWR_ON,
        pwr_on:     1'b1,
        irq:        1'b0,
        rt_rst:     1'b1,
        rst_cnt:    8'h00,
        blank_cnt:  4'h0,
        app_rst:    1'b1,
        app_cnt:    8'h00,
        hold_cnt:   '0,
        btn_prev_n: 1'b1,
        boot_mode:  `PBRBS_BOOT_INIT,
        boot_pd_en: `PBRBS_PD_ON,
        rt_pin:     OD_DRIVE,
        app_pin:    OD_DRIVE
    };

    pbrbs_state_t s_ff;
    pbrbs_state_t nxt_s;

    logic [3:0] pins_sync;
    logic       btn_db_n;
    logic       press;
    logic       force_off;
    logic       ext_rst;
    logic [1:0] boot_sync;

    function automatic logic boot_pick(input logic       fuse_en,
                                       input logic [1:0] fuse_val,
                                       input logic [1:0] pins,
                                       input int         idx);
        boot_pick = fuse_en ? fuse_val[idx] : pins[idx];
    endfunction : boot_pick

    pbrbs_sync u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({power_button_n, rt_domain_reset_n_sense, boot_sel_bit1, boot_sel_bit0}),
        .q   (pins_sync)
    );

    pbrbs_debounce #(
        .DEBOUNCE_CYC (DEBOUNCE_CYC)
    ) u_debounce (
        .clk     (clk),
        .rst     (rst),
        .raw_n   (pins_sync[`PBRBS_SYNC_BTN]),
        .level_n (btn_db_n)
    );

    assign boot_sync = {pins_sync[`PBRBS_SYNC_BOOT1], pins_sync[`PBRBS_SYNC_BOOT0]};
    // One event per debounced falling edge
    assign press     = s_ff.btn_prev_n & ~btn_db_n;
    assign force_off = ~btn_db_n & (s_ff.hold_cnt == HOLD_LAST);
    // Pin is only watched once our own drive has left the synchroniser
    assign ext_rst   = ~s_ff.rt_rst & (s_ff.blank_cnt == 4'h0) & ~pins_sync[`PBRBS_SYNC_RT];

    always_comb begin
        nxt_s            = s_ff;
        nxt_s.irq        = 1'b0;
        nxt_s.btn_prev_n = btn_db_n;
        if (ext_rst) begin
            nxt_s = ST_INIT;
        end else begin
            // Stretch the core reset, then blank the pin while our drive decays
            if (s_ff.rt_rst) begin
                if (s_ff.rst_cnt == RST_LAST) begin
                    nxt_s.rt_rst       = 1'b0;
                    nxt_s.blank_cnt    = `PBRBS_BLANK;
                    nxt_s.boot_mode[0] = boot_pick(fuse_boot_en, fuse_boot_mode, boot_sync, 0);
                end else begin
                    nxt_s.rst_cnt = s_ff.rst_cnt + 8'h01;
                end
            end else if (s_ff.blank_cnt != 4'h0) begin
                nxt_s.blank_cnt = s_ff.blank_cnt - 4'h1;
            end

            // Hold counter saturates so force-off stays asserted while held
            if (!btn_db_n) begin
                if (s_ff.hold_cnt != HOLD_LAST) begin
                    nxt_s.hold_cnt = s_ff.hold_cnt + `PBRBS_HOLD_W'(1);
                end
            end else begin
                nxt_s.hold_cnt = '0;
            end

            case (s_ff.pwr)
                PWR_OFF: begin
                    if (press) begin
                        nxt_s.pwr = PWR_ON;
                    end
                end
                PWR_ON: begin
                    if (force_off) begin
                        nxt_s.pwr = PWR_OFF;
                    end else if (press) begin
                        nxt_s.irq = 1'b1;
                    end
                end
                default: begin
                    nxt_s.pwr = PWR_OFF;
                end
            endcase

            // Power OFF keeps only the application core in reset
            if (s_ff.rt_rst || s_ff.pwr == PWR_OFF) begin
                nxt_s.app_rst = 1'b1;
                nxt_s.app_cnt = 8'h00;
            end else if (s_ff.app_rst) begin
                if (s_ff.app_cnt == APP_LAST) begin
                    nxt_s.app_rst      = 1'b0;
                    nxt_s.boot_mode[1] = boot_pick(fuse_boot_en, fuse_boot_mode, boot_sync, 1);
                end else begin
                    nxt_s.app_cnt = s_ff.app_cnt + 8'h01;
                end
            end
        end
        nxt_s.pwr_on = (nxt_s.pwr == PWR_ON);
        nxt_s.rt_pin = nxt_s.rt_rst ? OD_DRIVE : OD_INPUT;
        nxt_s.app_pin = nxt_s.app_rst ? OD_DRIVE : OD_INPUT;
        nxt_s.boot_pd_en = `PBRBS_PD_ON;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= ST_INIT;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // no button level leaves the block, only events
    assign rt_domain_reset_n_pin    = s_ff.rt_pin;
    assign app_core_reset_ind_n_pin = s_ff.app_pin;
    assign rt_core_rst              = s_ff.rt_rst;
    assign app_core_rst             = s_ff.app_rst;
    assign pwr_on                   = s_ff.pwr_on;
    assign pwr_irq                  = s_ff.irq;
    assign boot_mode                = s_ff.boot_mode;
    assign boot_sel_pd_en           = s_ff.boot_pd_en;

    // Power state, reset pin and boot mode checks
    chk_press_turns_on: assert property (@(posedge clk) disable iff (rst)
        (s_ff.pwr == PWR_OFF && press && !ext_rst) |=> (pwr_on && !pwr_irq))
        else $error("press in OFF did not turn the power on");

    chk_press_raises_irq: assert property (@(posedge clk) disable iff (rst)
        (s_ff.pwr == PWR_ON && press && !force_off && !ext_rst) |=> (pwr_irq && pwr_on) ##1 !pwr_irq)
        else $error("press in ON did not give a one-cycle interrupt");

    chk_irq_cause: assert property (@(posedge clk) disable iff (rst)
        pwr_irq |-> $past(press) && $past(s_ff.pwr == PWR_ON))
        else $error("interrupt without a press in ON");

    chk_force_off: assert property (@(posedge clk) disable iff (rst)
        (force_off && !ext_rst) |=> !pwr_on)
        else $error("long hold did not force the power off");

    chk_rt_pin_drive: assert property (@(posedge clk) disable iff (rst)
        rt_core_rst |-> (rt_domain_reset_n_pin.oe && !rt_domain_reset_n_pin.out
                         && !rt_domain_reset_n_pin.pu_en))
        else $error("real-time reset pin not driven low during core reset");

    chk_rt_pin_input: assert property (@(posedge clk) disable iff (rst)
        !rt_core_rst |-> (!rt_domain_reset_n_pin.oe && rt_domain_reset_n_pin.pu_en))
        else $error("real-time reset pin not an input with pull-up");

    chk_ext_reset: assert property (@(posedge clk) disable iff (rst)
        ext_rst |=> (rt_core_rst && app_core_rst && pwr_on) [*8])
        else $error("external reset did not hold the cores in reset");

    chk_app_pin_dir: assert property (@(posedge clk) disable iff (rst)
        (app_core_reset_ind_n_pin.oe == app_core_rst)
        && (app_core_reset_ind_n_pin.pu_en == !app_core_rst))
        else $error("application reset pin direction wrong");

    chk_app_follows_rt: assert property (@(posedge clk) disable iff (rst)
        (rt_core_rst || !pwr_on) |=> app_core_rst)
        else $error("application core left reset too early");

    chk_pulldown_on: assert property (@(posedge clk) disable iff (rst)
        boot_sel_pd_en == `PBRBS_PD_ON)
        else $error("boot select pull-downs switched off");

    chk_boot_sample: assert property (@(posedge clk) disable iff (rst)
        $fell(rt_core_rst) |-> boot_mode[0]
            == $past(fuse_boot_en ? fuse_boot_mode[0] : boot_sync[0]))
        else $error("boot bit 0 not captured at reset release");

    chk_boot_stable: assert property (@(posedge clk) disable iff (rst)
        (!rt_core_rst && !$fell(rt_core_rst) && !$fell(app_core_rst) && !$past(ext_rst))
        |-> $stable(boot_mode))
        else $error("boot mode changed outside a reset release");

    // Interrupt, power state cause, counter, pin and boot capture checks
    chk_irq_one_cycle: assert property (@(posedge clk) disable iff (rst)
        pwr_irq |=> !pwr_irq)
        else $error("interrupt pulse lasted more than one cycle");

    chk_irq_keeps_on: assert property (@(posedge clk) disable iff (rst)
        pwr_irq |-> (pwr_on && $past(pwr_on)))
        else $error("interrupt came with a power state change");

    chk_on_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(pwr_on) |-> ($past(press) || $past(ext_rst)))
        else $error("power turned on without a press");

    chk_off_cause: assert property (@(posedge clk) disable iff (rst)
        $fell(pwr_on) |-> $past(force_off))
        else $error("power turned off without a long hold");

    chk_hold_counts: assert property (@(posedge clk) disable iff (rst)
        (!btn_db_n && (s_ff.hold_cnt != HOLD_LAST) && !ext_rst)
        |=> (s_ff.hold_cnt == $past(s_ff.hold_cnt) + `PBRBS_HOLD_W'(1)))
        else $error("hold counter did not advance while the button was held");

    chk_hold_clear: assert property (@(posedge clk) disable iff (rst)
        btn_db_n |=> (s_ff.hold_cnt == '0))
        else $error("hold counter not cleared on release");

    chk_stretch_len: assert property (@(posedge clk) disable iff (rst)
        $fell(rt_core_rst) |-> ($past(s_ff.rst_cnt) == RST_LAST))
        else $error("real-time reset released before the stretch ran out");

    chk_watch_gap: assert property (@(posedge clk) disable iff (rst)
        $fell(rt_core_rst) |-> (s_ff.blank_cnt == `PBRBS_BLANK))
        else $error("pin blanking not started at reset release");

    chk_app_release: assert property (@(posedge clk) disable iff (rst)
        $fell(app_core_rst) |-> ($past(!rt_core_rst && pwr_on)
                                 && ($past(s_ff.app_cnt) == APP_LAST)))
        else $error("application core released out of order");

    chk_boot_bit1: assert property (@(posedge clk) disable iff (rst)
        $fell(app_core_rst) |-> boot_mode[1]
            == $past(fuse_boot_en ? fuse_boot_mode[1] : boot_sync[1]))
        else $error("boot bit 1 not captured at application release");

    chk_fuse_override: assert property (@(posedge clk) disable iff (rst)
        ($fell(rt_core_rst) && $past(fuse_boot_en))
        |-> (boot_mode[0] == $past(fuse_boot_mode[0])))
        else $error("fuse boot setting did not override the pins");

    chk_pin_out_low: assert property (@(posedge clk) disable iff (rst)
        !rt_domain_reset_n_pin.out && !app_core_reset_ind_n_pin.out)
        else $error("open-drain pin drives a high level");

    chk_ext_boot_clear: assert property (@(posedge clk) disable iff (rst)
        ext_rst |=> (boot_mode == `PBRBS_BOOT_INIT))
        else $error("external reset did not clear the boot mode");

    cov_turn_on: cover property (@(posedge clk) disable iff (rst)
        !pwr_on ##1 pwr_on);
    cov_irq: cover property (@(posedge clk) disable iff (rst) pwr_irq);
    cov_forced_off: cover property (@(posedge clk) disable iff (rst) force_off ##1 !pwr_on);
    cov_ext_reset: cover property (@(posedge clk) disable iff (rst) ext_rst);
    cov_fuse_boot: cover property (@(posedge clk) disable iff (rst)
        fuse_boot_en && $fell(app_core_rst));
endmodule : pbrbs_sequencer

// File: pbrbs_board_model.sv
// Board side model: pushbutton, external reset source and boot straps
`timescale 1ns/1ps
module pbrbs_board_model
    import pbrbs_pkg::*;
(
    input  wire logic       clk,
    input  pbrbs_od_t       rt_pin,
    input  wire logic [1:0] boot_sel_pd_en,
    output logic            power_button_n,
    output logic            rt_domain_reset_n_sense,
    output logic            boot_sel_bit0,
    output logic            boot_sel_bit1
);
    logic       ext_low;
    logic [1:0] strap_val;
    logic [1:0] strap_drv;
    logic       float_lvl;

    initial begin
        power_button_n = 1'b1;
        ext_low        = 1'b1;
        strap_val      = 2'h2;
        strap_drv      = 2'h3;
        float_lvl      = 1'b0;
    end

    // Undriven lines without a pull show a changing level
    always @(posedge clk) float_lvl <= ~float_lvl;

    always_comb begin
        if (rt_pin.oe || ext_low)
            rt_domain_reset_n_sense = 1'b0;
        else if (rt_pin.pu_en)
            rt_domain_reset_n_sense = 1'b1;
        else
            rt_domain_reset_n_sense = float_lvl;
    end

    always_comb begin
        boot_sel_bit0 = strap_drv[0] ? strap_val[0] : (boot_sel_pd_en[0] ? 1'b0 : float_lvl);
        boot_sel_bit1 = strap_drv[1] ? strap_val[1] : (boot_sel_pd_en[1] ? 1'b0 : float_lvl);
    end

    task automatic release_por();
        ext_low = 1'b0;
    endtask : release_por

    task automatic press(input int cycles);
        @(posedge clk);
        #1 power_button_n = 1'b0;
        repeat (cycles) @(posedge clk);
        #1 power_button_n = 1'b1;
    endtask : press

    task automatic pull_reset(input int cycles);
        @(posedge clk);
        #1 ext_low = 1'b1;
        repeat (cycles) @(posedge clk);
        #1 ext_low = 1'b0;
    endtask : pull_reset

    task automatic set_straps(input logic [1:0] drv, input logic [1:0] val);
        @(posedge clk);
        #1 strap_drv = drv;
        strap_val = val;
    endtask : set_straps
endmodule : pbrbs_board_model

// File: testbench.sv
// Self-checking bench for the power button sequencer with a board model
`timescale 1ns/1ps
module testbench;
    import pbrbs_pkg::*;
    localparam int unsigned FORCE_CYC = 200;
    localparam int unsigned DB_CYC    = 8;

    logic       clk;
    logic       rst;
    logic       fuse_boot_en;
    logic [1:0] fuse_boot_mode;
    logic       power_button_n;
    logic       rt_in;
    logic       bit0;
    logic       bit1;
    pbrbs_od_t  rt_pin;
    pbrbs_od_t  app_pin;
    logic       rt_core_rst;
    logic       app_core_rst;
    logic       pwr_on;
    logic       pwr_irq;
    logic [1:0] boot_mode;
    logic [1:0] boot_sel_pd_en;
    int         fail_count;
    int         checks_done;
    int         irq_seen;

    pbrbs_sequencer #(.FORCE_OFF_CYC(FORCE_CYC), .DEBOUNCE_CYC(DB_CYC)) i_dut (
        .clk(clk), .rst(rst), .power_button_n(power_button_n),
        .rt_domain_reset_n_sense(rt_in), .boot_sel_bit0(bit0), .boot_sel_bit1(bit1),
        .fuse_boot_en(fuse_boot_en), .fuse_boot_mode(fuse_boot_mode),
        .rt_domain_reset_n_pin(rt_pin), .app_core_reset_ind_n_pin(app_pin),
        .rt_core_rst(rt_core_rst), .app_core_rst(app_core_rst), .pwr_on(pwr_on),
        .pwr_irq(pwr_irq), .boot_mode(boot_mode), .boot_sel_pd_en(boot_sel_pd_en)
    );

    pbrbs_board_model i_board (
        .clk(clk), .rt_pin(rt_pin), .boot_sel_pd_en(boot_sel_pd_en),
        .power_button_n(power_button_n), .rt_domain_reset_n_sense(rt_in),
        .boot_sel_bit0(bit0), .boot_sel_bit1(bit1)
    );

    always #4 clk = ~clk;

    always @(posedge clk) if (pwr_irq === 1'b1) irq_seen++;

    task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_app();
        int i;
        for (i = 0; i < 120 && app_core_rst !== 1'b0; i++) @(posedge clk);
        #1;
    endtask : wait_app

    task automatic test_por();
        int i;
        chk("rt pin", 2'h2, {rt_pin.oe, rt_pin.pu_en});
        chk("pull-downs", 2'h3, boot_sel_pd_en);
        chk("pin out", 2'h0, {rt_pin.out, app_pin.out});
        for (i = 0; i < 100 && rt_core_rst !== 1'b0; i++) @(posedge clk);
        #1;
        chk("rt pin", 2'h1, {rt_pin.oe, rt_pin.pu_en});
        chk("app pin", 2'h2, {app_pin.oe, app_pin.pu_en});
        wait_app();
        chk("app pin", 2'h1, {app_pin.oe, app_pin.pu_en});
        chk("boot_mode", 2'h2, boot_mode);
        $display("test_por done");
    endtask : test_por

    task automatic test_press();
        int irq0;
        irq0 = irq_seen;
        i_board.press(DB_CYC - 4);
        repeat (30) @(posedge clk);
        chk("irq count short", 2'h0, 2'(irq_seen - irq0));
        i_board.press(DB_CYC + 6);
        repeat (30) @(posedge clk);
        #1;
        chk("irq count", 2'h1, 2'(irq_seen - irq0));
        chk("pwr_on", 2'h1, {1'b0, pwr_on});
        $display("test_press done");
    endtask : test_press

    task automatic test_force_off();
        i_board.set_straps(2'h3, 2'h1);
        fork
            i_board.press(DB_CYC + FORCE_CYC + 30);
            begin
                repeat (DB_CYC + FORCE_CYC - 20) @(posedge clk);
                #1 chk("pwr_on early", 2'h1, {1'b0, pwr_on});
            end
        join
        #1;
        chk("pwr_on", 2'h0, {1'b0, pwr_on});
        chk("app reset", 2'h3, {app_core_rst, app_pin.oe});
        repeat (20) @(posedge clk);
        i_board.press(DB_CYC + 6);
        repeat (20) @(posedge clk);
        #1 chk("pwr_on", 2'h1, {1'b0, pwr_on});
        wait_app();
        chk("boot_mode", 2'h0, boot_mode);
        $display("test_force_off done");
    endtask : test_force_off

    task automatic test_ext_reset(input logic en, input logic [1:0] fv,
                                  input logic [1:0] drv, input logic [1:0] exp);
        fuse_boot_en = en;
        fuse_boot_mode = fv;
        i_board.set_straps(drv, 2'h3);
        i_board.pull_reset(4);
        chk("rt reset", 2'h3, {rt_core_rst, rt_pin.oe});
        wait_app();
        chk("boot_mode", exp, boot_mode);
        $display("test_ext_reset done");
    endtask : test_ext_reset

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Whole run needs about 550 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        fuse_boot_en = 1'b0;
        fuse_boot_mode = 2'h0;
        fail_count = 0;
        checks_done = 0;
        irq_seen = 0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        i_board.release_por();
        test_por();
        test_press();
        test_force_off();
        test_ext_reset(1'b0, 2'h0, 2'h0, 2'h0);
        test_ext_reset(1'b1, 2'h1, 2'h3, 2'h1);
        summarize();
    end
endmodule : testbench
